// [hw/chcl_defines.svh]
// Purpose: offsets, field positions, reset values and decode figures for the charger config/lock registers
// Assumes: 8-bit registers on an 8-bit register address space
// Notes:   included by its bare name
`ifndef CHCL_DEFINES_SVH
`define CHCL_DEFINES_SVH

// ==========================================================================
// register offsets
`define CHCL_OFS_TERM_VOLT        8'h1a
`define CHCL_OFS_TRICKLE_OVC      8'h1b
`define CHCL_OFS_LOCK_WDOG        8'h1c
`define CHCL_OFS_THERMAL_PROFILE  8'h1d

// ==========================================================================
// reset values
`define CHCL_RST_TERM_VOLT        8'h00
`define CHCL_RST_TRICKLE_OVC      8'h44
`define CHCL_RST_LOCK_WDOG        8'h00
`define CHCL_RST_THERMAL_PROFILE  8'h00

// ==========================================================================
// field positions
`define CHCL_TV_CODE_MSB          5
`define CHCL_TO_RSVD_MSB          7
`define CHCL_TO_RSVD_LSB          6
`define CHCL_TO_PRE_MSB           5
`define CHCL_TO_PRE_LSB           4
`define CHCL_TO_OVC_MSB           3
`define CHCL_TO_OVC_LSB           0
`define CHCL_LW_SPARE_HI          7
`define CHCL_LW_RSVD_MSB          6
`define CHCL_LW_RSVD_LSB          5
`define CHCL_LW_SPARE_MID         4
`define CHCL_LW_KEY_MSB           3
`define CHCL_LW_KEY_LSB           2
`define CHCL_LW_KICK_MSB          1
`define CHCL_LW_KICK_LSB          0
`define CHCL_TP_ENABLE_BIT        7

// ==========================================================================
// codes
`define CHCL_KEY_UNLOCK           2'h3
`define CHCL_KICK_RESTART         2'h1
`define CHCL_OVC_DISABLED         4'h0

// ==========================================================================
// decode figures, in mA and mV
`define CHCL_PRE_BASE_MA          12'h064
`define CHCL_PRE_STEP_MA          12'h064
`define CHCL_OVC_BASE_MA          16'h0bb8
`define CHCL_OVC_STEP_MA          16'h01f4
`define CHCL_TV3_BASE_MV          16'h2ee0
`define CHCL_TV3_STEP_MV          16'h001e
`define CHCL_TV2_BASE_MV          16'h1f40
`define CHCL_TV2_STEP_MV          16'h0014

`endif

// [hw/chcl_pkg.sv]
// Purpose: types for the charger config/lock registers
// Assumes: constants live in chcl_defines.svh
// Notes:   nothing else
package chcl_pkg;

  typedef enum logic [0:0] {
    CHCL_PACK_TWO_CELL,
    CHCL_PACK_THREE_CELL
  } chcl_pack_t;

endpackage

// [hw/chcl_regs.sv]
// Purpose: charger configuration slice with settings-lock key and watchdog kick
// Assumes: simple synchronous register port; write and read strobes one cycle wide
// Notes:   read data registered one cycle after rd_en; offsets outside the slice read 8'h00
`include "chcl_defines.svh"

// Summary of operation
// - writing 11 to the lock key field unlocks the protected registers.
// - any other key code locks the protected registers against writes.
// - kick code 01 restarts the watchdog while enabled; other codes do nothing.
// - precharge select codes 0..3 give 100, 200, 300, 400 mA.
// - overcurrent code 0 disables; codes 1..15 give 3.0 A to 10.0 A by 0.5 A.
// - termination code reads back as programmed in bits 5:0; the thermal profile does not touch it.
module chcl_regs (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        pack_three_cell,
  input  wire logic        watchdog_enable,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  output logic             settings_unlocked,
  output logic             watchdog_restart,
  output logic             overcurrent_enable,
  output logic      [15:0] overcurrent_limit_ma,
  output logic      [11:0] precharge_current_ma,
  output logic      [15:0] termination_voltage_mv,
  output logic             thermal_profile_enable
);

  // ==========================================================================
  // registers
  logic [7:0] term_volt_r;
  logic [7:0] trickle_ovc_r;
  logic [7:0] lock_wdog_r;
  logic [7:0] thermal_profile_r;
  logic       pack_meta_r;
  logic       pack_sync_r;
  logic       wden_meta_r;
  logic       wden_sync_r;

  logic wr_tv;
  logic wr_to;
  logic wr_lw;
  logic wr_tp;

  // protected registers: termination voltage and thermal profile
  assign wr_tv = wr_en && (addr == `CHCL_OFS_TERM_VOLT) && settings_unlocked;
  assign wr_tp = wr_en && (addr == `CHCL_OFS_THERMAL_PROFILE) && settings_unlocked;
  assign wr_to = wr_en && (addr == `CHCL_OFS_TRICKLE_OVC);
  assign wr_lw = wr_en && (addr == `CHCL_OFS_LOCK_WDOG);

  // ==========================================================================
  // decode functions
  function automatic logic [15:0] ovc_ma(input logic [3:0] code);
    logic [15:0] steps;
    steps = {12'h000, code} - 16'h0001;
    ovc_ma = (code == `CHCL_OVC_DISABLED) ? 16'h0000 : 16'(`CHCL_OVC_BASE_MA + steps * `CHCL_OVC_STEP_MA);
  endfunction

  function automatic logic [15:0] term_mv(input logic [5:0] code, input logic three);
    logic [15:0] c;
    c = {10'h000, code};
    if (three) begin
      term_mv = 16'(`CHCL_TV3_BASE_MV + c * `CHCL_TV3_STEP_MV);
    end else begin
      term_mv = 16'(`CHCL_TV2_BASE_MV + c * `CHCL_TV2_STEP_MV);
    end
  endfunction

  function automatic logic [11:0] pre_ma(input logic [1:0] code);
    pre_ma = 12'(`CHCL_PRE_BASE_MA + {10'h000, code} * `CHCL_PRE_STEP_MA);
  endfunction

  // ==========================================================================
  // pin synchronisers
  // both pins are slow levels, so a two-stage chain is enough
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pack_meta_r <= 1'b0;
      pack_sync_r <= 1'b0;
      wden_meta_r <= 1'b0;
      wden_sync_r <= 1'b0;
    end else begin
      pack_meta_r <= pack_three_cell;
      pack_sync_r <= pack_meta_r;
      wden_meta_r <= watchdog_enable;
      wden_sync_r <= wden_meta_r;
    end
  end

  // ==========================================================================
  // register writes
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      term_volt_r <= `CHCL_RST_TERM_VOLT;
    end else if (wr_tv) begin
      term_volt_r <= {2'h0, wr_data[`CHCL_TV_CODE_MSB:0]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      thermal_profile_r <= `CHCL_RST_THERMAL_PROFILE;
    end else if (wr_tp) begin
      thermal_profile_r <= wr_data;
    end
  end

  // reserved bits stored as written; host keeps them at default
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      trickle_ovc_r <= `CHCL_RST_TRICKLE_OVC;
    end else if (wr_to) begin
      trickle_ovc_r <= wr_data;
    end
  end

  // kick field is write-action only and always reads back 00
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lock_wdog_r <= `CHCL_RST_LOCK_WDOG;
    end else if (wr_lw) begin
      lock_wdog_r <= {wr_data[7:2], 2'h0};
    end
  end

  // ==========================================================================
  // lock state and watchdog restart
  // every write to the lock register sets or drops the lock, not only key changes;
  // the restart is a one-cycle pulse, the timer itself sits outside this slice
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      settings_unlocked <= 1'b0;
    end else if (wr_lw) begin
      settings_unlocked <= (wr_data[`CHCL_LW_KEY_MSB:`CHCL_LW_KEY_LSB] == `CHCL_KEY_UNLOCK);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      watchdog_restart <= 1'b0;
    end else begin
      watchdog_restart <= wr_lw && wden_sync_r &&
                          (wr_data[`CHCL_LW_KICK_MSB:`CHCL_LW_KICK_LSB] == `CHCL_KICK_RESTART);
    end
  end

  // ==========================================================================
  // decoded settings
  // decodes trail the stored fields by one cycle, so a write never glitches them
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      precharge_current_ma <= `CHCL_PRE_BASE_MA;
    end else begin
      precharge_current_ma <= pre_ma(trickle_ovc_r[`CHCL_TO_PRE_MSB:`CHCL_TO_PRE_LSB]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      overcurrent_enable   <= 1'b1;
      overcurrent_limit_ma <= 16'h0000;
    end else begin
      overcurrent_enable   <= (trickle_ovc_r[`CHCL_TO_OVC_MSB:`CHCL_TO_OVC_LSB] != `CHCL_OVC_DISABLED);
      overcurrent_limit_ma <= ovc_ma(trickle_ovc_r[`CHCL_TO_OVC_MSB:`CHCL_TO_OVC_LSB]);
    end
  end

  // pack size comes through the synchroniser, so a pack swap shows three cycles later
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      termination_voltage_mv <= 16'h0000;
    end else begin
      termination_voltage_mv <= term_mv(term_volt_r[`CHCL_TV_CODE_MSB:0],
                                        pack_sync_r == chcl_pkg::CHCL_PACK_THREE_CELL);
    end
  end

  // only the enable leaves the slice; readback of the code ignores it
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      thermal_profile_enable <= 1'b0;
    end else begin
      thermal_profile_enable <= thermal_profile_r[`CHCL_TP_ENABLE_BIT];
    end
  end

  // ==========================================================================
  // read port
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
    end
  end

  // idle data held at zero so a late sample never shows a stale register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
    end else begin
      if (!rd_en) begin
        rd_data <= 8'h00;
      end else if (addr == `CHCL_OFS_TERM_VOLT) begin
        rd_data <= term_volt_r;
      end else if (addr == `CHCL_OFS_TRICKLE_OVC) begin
        rd_data <= trickle_ovc_r;
      end else if (addr == `CHCL_OFS_LOCK_WDOG) begin
        rd_data <= lock_wdog_r;
      end else if (addr == `CHCL_OFS_THERMAL_PROFILE) begin
        rd_data <= thermal_profile_r;
      end else begin
        rd_data <= 8'h00;
      end
    end
  end

endmodule

// [tb/charger_config_lock_regs_tb.sv]
// Purpose: self-checking bench for chcl_regs
// Assumes: 250 MHz clock, sync reset
// Notes:   unanswered reads come back unknown and fail
module charger_config_lock_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst_b, wr_en, rd_en, rd_valid, pack_three_cell, watchdog_enable;
  logic        settings_unlocked, watchdog_restart, overcurrent_enable, thermal_profile_enable;
  logic [7:0]  addr, wr_data, rd_data;
  logic [11:0] precharge_current_ma;
  logic [15:0] overcurrent_limit_ma, termination_voltage_mv;
  int          num_errors = 0;
  int          n_compared = 0;
  chcl_regs chcl_regs_i (
    .ref_clk                (ref_clk),
    .rst_b                  (rst_b),
    .wr_en                  (wr_en),
    .rd_en                  (rd_en),
    .addr                   (addr),
    .wr_data                (wr_data),
    .pack_three_cell        (pack_three_cell),
    .watchdog_enable        (watchdog_enable),
    .rd_data                (rd_data),
    .rd_valid               (rd_valid),
    .settings_unlocked      (settings_unlocked),
    .watchdog_restart       (watchdog_restart),
    .overcurrent_enable     (overcurrent_enable),
    .overcurrent_limit_ma   (overcurrent_limit_ma),
    .precharge_current_ma   (precharge_current_ma),
    .termination_voltage_mv (termination_voltage_mv),
    .thermal_profile_enable (thermal_profile_enable)
  );
  chcl_host chcl_host_i (
    .ref_clk  (ref_clk),
    .rd_data  (rd_data),
    .rd_valid (rd_valid),
    .wr_en    (wr_en),
    .rd_en    (rd_en),
    .addr     (addr),
    .wr_data  (wr_data)
  );
  always #2 ref_clk = ~ref_clk;
  // ====================
  // checks and scenarios
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compared %0d, wrong %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_lock();
    logic [7:0] d;
    chcl_host_i.rd(8'h1b, d);
    chk({8'h00, d}, 16'h0044);
    chcl_host_i.wr(8'h1a, 8'h05);
    chcl_host_i.rd(8'h1a, d);
    chk({8'h00, d}, 16'h0000);
    chcl_host_i.wr(8'h1c, 8'h0c);
    chcl_host_i.wr(8'h1a, 8'h3a);
    chk({15'h0, settings_unlocked}, 16'h0001);
    chcl_host_i.rd(8'h1a, d);
    chk({8'h00, d}, 16'h003a);
    chk(termination_voltage_mv, 16'h35ac);
    @(posedge ref_clk);
    pack_three_cell <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk(termination_voltage_mv, 16'h23c8);
    for (int k = 0; k < 3; k++) begin
      chcl_host_i.wr(8'h1c, {4'h0, 2'(k), 2'h0});
      chcl_host_i.wr(8'h1a, 8'h11);
      chcl_host_i.rd(8'h1a, d);
      chk({8'h00, d}, 16'h003a);
      chcl_host_i.wr(8'h1c, 8'h0c);
    end
    $display("test lock done");
  endtask
  task automatic t_profile();
    logic [7:0] d;
    chcl_host_i.wr(8'h1d, 8'h80);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({15'h0, thermal_profile_enable}, 16'h0001);
    chcl_host_i.rd(8'h1a, d);
    chk({8'h00, d}, 16'h003a);
    chcl_host_i.wr(8'h1c, 8'h9d);
    chcl_host_i.rd(8'h1c, d);
    chk({8'h00, d}, 16'h009c);
    chcl_host_i.wr(8'h1c, 8'h00);
    chcl_host_i.wr(8'h1d, 8'h00);
    chcl_host_i.rd(8'h1d, d);
    chk({8'h00, d}, 16'h0080);
    chk({15'h0, thermal_profile_enable}, 16'h0001);
    chcl_host_i.rd(8'h1e, d);
    chk({8'h00, d}, 16'h0000);
    chcl_host_i.wr(8'h1c, 8'h0c);
    $display("test profile done");
  endtask
  task automatic t_reset();
    logic [7:0] d;
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({15'h0, settings_unlocked}, 16'h0000);
    chk({4'h0, precharge_current_ma}, 16'h0064);
    chk({15'h0, thermal_profile_enable}, 16'h0000);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(overcurrent_limit_ma, 16'h1194);
    chk(termination_voltage_mv, 16'h1f40);
    chcl_host_i.rd(8'h1b, d);
    chk({8'h00, d}, 16'h0044);
    $display("test reset done");
  endtask
  task automatic t_decode();
    for (int c = 0; c < 16; c++) begin
      chcl_host_i.wr(8'h1b, {2'h1, 2'(c), 4'(c)});
      repeat (2) @(posedge ref_clk);
      #1;
      chk({4'h0, precharge_current_ma}, 16'h0064 + 16'h0064 * 16'(c % 4));
      chk(overcurrent_limit_ma, c == 0 ? 16'h0000 : 16'h09c4 + 16'h01f4 * 16'(c));
      chk({15'h0, overcurrent_enable}, {15'h0, c != 0});
    end
    $display("test decode done");
  endtask
  task automatic t_kick();
    // second half repeats the codes with the watchdog off
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk);
      watchdog_enable <= k < 4;
      repeat (4) @(posedge ref_clk);
      chcl_host_i.wr(8'h1c, {6'h03, 2'(k)});
      #1;
      chk({15'h0, watchdog_restart}, {15'h0, k == 1});
    end
    $display("test kick done");
  endtask
  initial begin
    #100us;
    num_errors++;
    close_out();
  end
  initial begin
    rst_b = 1'b0;
    pack_three_cell = 1'b1;
    watchdog_enable = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_lock();
    t_profile();
    t_decode();
    t_kick();
    t_reset();
    close_out();
  end
endmodule

// [tb/chcl_checker.sv]
// Purpose: port assertions for chcl_regs
// Assumes: one clock, sync active-low reset
// Notes:   bound at foot
module chcl_checker (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  addr,
  input wire logic [7:0]  wr_data,
  input wire logic        watchdog_enable,
  input wire logic [7:0]  rd_data,
  input wire logic        rd_valid,
  input wire logic        settings_unlocked,
  input wire logic        watchdog_restart,
  input wire logic        overcurrent_enable,
  input wire logic [15:0] overcurrent_limit_ma,
  input wire logic [11:0] precharge_current_ma
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ====================
  // write sequences
  sequence key_wr; wr_en && addr == 8'h1c; endsequence
  // lone write, so the decode is not overtaken by a second one
  sequence cfg_wr; wr_en && addr == 8'h1b ##1 !(wr_en && addr == 8'h1b); endsequence
  unlock_on_key_a: assert property (key_wr ##0 wr_data[3:2] == 2'h3 |=> settings_unlocked)
    else $error("unlock missing");
  lock_on_key_a: assert property (key_wr ##0 wr_data[3:2] != 2'h3 |=> !settings_unlocked)
    else $error("lock missing");
  lock_cause_a: assert property (!$stable(settings_unlocked) |-> $past(wr_en && addr == 8'h1c))
    else $error("lock moved alone");
  kick_fires_a: assert property (watchdog_enable[*4] ##0 key_wr ##0 wr_data[1:0] == 2'h1 |=> watchdog_restart)
    else $error("kick lost");
  kick_cause_a: assert property (watchdog_restart |-> $past(wr_en && addr == 8'h1c && wr_data[1:0] == 2'h1))
    else $error("stray kick");
  pre_decode_a: assert property (cfg_wr |=> precharge_current_ma == 12'h064 + 12'h064 * $past(wr_data[5:4], 2))
    else $error("precharge decode");
  ovc_decode_a: assert property (cfg_wr |=> overcurrent_enable == ($past(wr_data[3:0], 2) != 4'h0)
    && overcurrent_limit_ma == ($past(wr_data[3:0], 2) != 4'h0 ? 16'h09c4 + 16'h01f4 * $past(wr_data[3:0], 2) : 16'h0000))
    else $error("overcurrent decode");
  read_pulse_a: assert property (rd_en |=> rd_valid)
    else $error("read answer missing");
  read_idle_a: assert property (!rd_en |=> !rd_valid && rd_data == 8'h00)
    else $error("read data outside read");
endmodule
bind chcl_regs chcl_checker chcl_checker_i (
  .ref_clk              (ref_clk),
  .rst_b                (rst_b),
  .wr_en                (wr_en),
  .rd_en                (rd_en),
  .addr                 (addr),
  .wr_data              (wr_data),
  .watchdog_enable      (watchdog_enable),
  .rd_data              (rd_data),
  .rd_valid             (rd_valid),
  .settings_unlocked    (settings_unlocked),
  .watchdog_restart     (watchdog_restart),
  .overcurrent_enable   (overcurrent_enable),
  .overcurrent_limit_ma (overcurrent_limit_ma),
  .precharge_current_ma (precharge_current_ma)
);

// [tb/chcl_host.sv]
// Purpose: host model driving the register port
// Assumes: one request per call, answer one cycle later
// Notes:   released data shows the inverse of the last byte
module chcl_host (
  input  wire logic       ref_clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [7:0] addr,
  output logic      [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
  end
  // ====================
  // bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 8'h1b) v[7:6] = 2'h1;
    if (a == 8'h1c) v[6:5] = 2'h0;
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    wr_data <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    if (rd_valid === 1'b1) d = rd_data;
  endtask
endmodule
